//--- design/vrt_ctrl.sv
// Vector mapping, device reset sources, reset start-up and trap priority logic
`timescale 1ns/1ps
`default_nettype none
module vrt_ctrl #(
	parameter logic [23:0] PROG_MEM_END = vrt_pkg::PROG_MEM_END_DEFAULT
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [vrt_pkg::NUM_SRC-1:0] irq_flag_i,
	input wire logic [vrt_pkg::NUM_SRC-1:0] irq_enable_i,
	input wire logic [3*vrt_pkg::NUM_SRC-1:0] irq_level_i,
	input wire logic external_request_zero_i,
	input wire logic serial1_receive_request_i,
	input wire logic serial1_transmit_request_i,
	input wire logic [3:0] cpu_priority_level_i,
	input wire logic [vrt_pkg::NUM_TRAP-1:0] trap_req_i,
	input wire logic insn_done_i,
	input wire logic trap_ack_i,
	input wire logic trap_return_i,
	input wire logic trap_vec_taken_i,
	input wire logic [vrt_pkg::PC_W-1:0] trap_vec_addr_i,
	input wire logic watchdog_expired_i,
	input wire logic uninit_wreg_ptr_i,
	input wire logic illegal_opcode_exec_i,
	input wire logic insn_flushed_i,
	input wire logic supply_dip_reset_i,
	input wire logic boot_word_valid_i,
	input wire logic [vrt_pkg::PC_W-1:0] boot_word_i,
	output var vrt_pkg::vrt_irq_grant_s irq_grant_o,
	output var vrt_pkg::vrt_trap_grant_s trap_grant_o,
	output logic priority_top_bit_o,
	output logic dev_reset_o,
	output var vrt_pkg::vrt_reset_cause_s reset_cause_o,
	output logic boot_fetch_req_o,
	output logic [vrt_pkg::PC_W-1:0] boot_fetch_addr_o,
	output logic start_valid_o,
	output logic [vrt_pkg::PC_W-1:0] start_addr_o
);
	import vrt_pkg::*;

	// ==========================================================
	// Supply dip synchroniser
	// The detector sits in the analog domain, so it passes three stages
	logic dip_s1_q, dip_s2_q, dip_s3_q, dip_q;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			dip_s1_q <= 1'b0;
			dip_s2_q <= 1'b0;
			dip_s3_q <= 1'b0;
			dip_q <= 1'b0;
		end else begin
			dip_s1_q <= supply_dip_reset_i;
			dip_s2_q <= dip_s1_q;
			dip_s3_q <= dip_s2_q;
			if (dip_s2_q == dip_s3_q) begin
				dip_q <= dip_s3_q;
			end
		end
	end

	// ==========================================================
	// Device reset sources
	vrt_reset_cause_s cause_d;
	logic soft_rst;
	logic [3:0] rst_cnt_q;

	always_comb begin
		cause_d.watchdog = watchdog_expired_i;
		cause_d.uninit_wreg = uninit_wreg_ptr_i;
		cause_d.illegal_op = illegal_opcode_exec_i & ~insn_flushed_i;
		cause_d.supply_dip = dip_q;
		cause_d.lockout = ($countones(trap_req_i) > 1);
	end

	assign soft_rst = dev_reset_o;

	// Exactly these five causes start the reset pulse
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			dev_reset_o <= 1'b0;
			rst_cnt_q <= 4'h0;
			reset_cause_o <= '0;
		end else if (|cause_d) begin
			dev_reset_o <= 1'b1;
			rst_cnt_q <= DEV_RESET_CYCLES;
			reset_cause_o <= cause_d;
		end else if (rst_cnt_q != 4'h0) begin
			rst_cnt_q <= rst_cnt_q - 4'h1;
			dev_reset_o <= (rst_cnt_q != 4'h1);
		end else begin
			dev_reset_o <= 1'b0;
		end
	end

	// ==========================================================
	// Start-up sequence
	// Interrupts stay quiet until the start address is reached
	vrt_boot_e boot_st_q;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || soft_rst) begin
			boot_st_q <= BOOT_GOTO;
			boot_fetch_req_o <= 1'b1;
			boot_fetch_addr_o <= BOOT_GOTO_ADDR;
			start_valid_o <= 1'b0;
			start_addr_o <= BOOT_GOTO_ADDR;
		end else begin
			start_valid_o <= 1'b0;
			unique case (boot_st_q)
				BOOT_GOTO: begin
					if (boot_word_valid_i) begin
						boot_st_q <= BOOT_TARGET;
						boot_fetch_addr_o <= BOOT_TARGET_ADDR;
					end
				end
				BOOT_TARGET: begin
					if (boot_word_valid_i) begin
						boot_st_q <= BOOT_RUN;
						boot_fetch_req_o <= 1'b0;
						start_valid_o <= 1'b1;
						start_addr_o <= boot_word_i;
					end
				end
				BOOT_RUN: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Interrupt arbitration
	logic [NUM_SRC-1:0] src_req;
	logic [2:0] best_lvl;
	logic [IDX_W-1:0] best_idx;
	logic best_valid;

	always_comb begin
		src_req = irq_flag_i & irq_enable_i;
		src_req[EXT_REQ0_NUM] = external_request_zero_i & irq_enable_i[EXT_REQ0_NUM];
		src_req[SERIAL1_RX_NUM] = serial1_receive_request_i & irq_enable_i[SERIAL1_RX_NUM];
		src_req[SERIAL1_TX_NUM] = serial1_transmit_request_i & irq_enable_i[SERIAL1_TX_NUM];
		best_lvl = LEVEL_OFF;
		best_idx = '0;
		// Strict compare keeps the lowest number on a tie
		for (int i = 0; i < NUM_SRC; i++) begin
			if (src_req[i] && (irq_level_i[3*i +: 3] > best_lvl)) begin
				best_lvl = irq_level_i[3*i +: 3];
				best_idx = IDX_W'(i);
			end
		end
		// A processor level of seven or a running trap masks everything
		best_valid = (best_lvl != LEVEL_OFF)
			&& ({1'b0, best_lvl} > cpu_priority_level_i);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || soft_rst) begin
			irq_grant_o <= '0;
		end else begin
			irq_grant_o.valid <= best_valid && (boot_st_q == BOOT_RUN);
			irq_grant_o.number <= best_idx;
			irq_grant_o.vector <= {2'b00, best_idx} + IRQ_VECTOR_OFFSET;
			irq_grant_o.level <= best_lvl;
		end
	end

	// ==========================================================
	// Trap pending and fixed priority
	logic [NUM_TRAP-1:0] trap_pend_q;
	logic [NUM_TRAP-1:0] trap_set;
	logic [NUM_TRAP-1:0] trap_clr;
	logic bad_vec;
	logic [2:0] trap_idx;
	logic trap_any;
	logic trap_elig;

	assign bad_vec = trap_vec_taken_i
		&& ((trap_vec_addr_i < VECTOR_SPACE_END) || (trap_vec_addr_i >= PROG_MEM_END));

	always_comb begin
		trap_set = trap_req_i;
		trap_set[ADDR_ERR_IDX] = trap_req_i[ADDR_ERR_IDX] | bad_vec;
		trap_clr = '0;
		if (trap_ack_i && trap_grant_o.valid) begin
			trap_clr[trap_grant_o.vector] = 1'b1;
		end
		trap_idx = 3'h0;
		trap_any = 1'b0;
		// Higher index is higher level, so the last hit wins
		for (int t = 0; t < NUM_TRAP; t++) begin
			// A trap acknowledged this cycle must not be offered again at a boundary
			if (trap_pend_q[t] && !trap_clr[t]) begin
				trap_idx = 3'(t);
				trap_any = 1'b1;
			end
		end
		// No enable gates a trap; only an equal or higher trap holds it off
		trap_elig = trap_any && (({1'b0, trap_idx} + TRAP_LEVEL_BASE) > cpu_priority_level_i);
	end

	// A new event in the clearing cycle stays pending
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || soft_rst) begin
			trap_pend_q <= '0;
		end else begin
			trap_pend_q <= (trap_pend_q & ~trap_clr) | trap_set;
		end
	end

	// Presented only at an instruction boundary, held until acknowledged
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || soft_rst) begin
			trap_grant_o <= '0;
		end else if (insn_done_i && !(trap_grant_o.valid && !trap_ack_i)) begin
			trap_grant_o.valid <= trap_elig;
			trap_grant_o.vector <= trap_idx;
			trap_grant_o.level <= {1'b0, trap_idx} + TRAP_LEVEL_BASE;
		end else if (trap_ack_i) begin
			trap_grant_o.valid <= 1'b0;
		end
	end

	// Nesting depth tracks how long the top bit must stay set
	logic [3:0] trap_depth_q;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || soft_rst) begin
			trap_depth_q <= 4'h0;
			priority_top_bit_o <= 1'b0;
		end else begin
			if (trap_ack_i && trap_grant_o.valid && !trap_return_i) begin
				trap_depth_q <= trap_depth_q + 4'h1;
				priority_top_bit_o <= 1'b1;
			end else if (trap_return_i && !(trap_ack_i && trap_grant_o.valid)
				&& trap_depth_q != 4'h0) begin
				trap_depth_q <= trap_depth_q - 4'h1;
				priority_top_bit_o <= (trap_depth_q != 4'h1);
			end
		end
	end

	// ==========================================================
	// Checks
	AST_VECTOR_OFFSET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		irq_grant_o.valid |-> irq_grant_o.vector == {2'b00, irq_grant_o.number} + 8'h08)
		else $error("vector is not number plus eight");

	AST_SERIAL_RX: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(irq_grant_o.valid && irq_grant_o.number == 6'h09) |-> irq_grant_o.vector == 8'h11)
		else $error("serial receive vector wrong");

	AST_LEVEL_ABOVE_CPU: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		irq_grant_o.valid |-> (irq_grant_o.level != 3'h0)
			&& ({1'b0, irq_grant_o.level} > $past(cpu_priority_level_i)))
		else $error("granted level not above processor level");

	AST_LEVEL_SEVEN_BLOCKS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$past(cpu_priority_level_i) == 4'h7 |-> !irq_grant_o.valid)
		else $error("interrupt granted at processor level seven");

	AST_TIE_LOWEST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(irq_grant_o.valid && $past(src_req[SERIAL1_RX_NUM])
			&& $past(irq_level_i[3*SERIAL1_RX_NUM +: 3]) == irq_grant_o.level)
			|-> irq_grant_o.number <= SERIAL1_RX_NUM)
		else $error("tie not won by lowest number");

	AST_WATCHDOG_RESET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		watchdog_expired_i |=> (dev_reset_o && reset_cause_o.watchdog) [*3])
		else $error("watchdog did not hold device reset");

	AST_FLUSHED_ILLEGAL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(illegal_opcode_exec_i && insn_flushed_i && !watchdog_expired_i && !uninit_wreg_ptr_i
			&& !dip_q && $countones(trap_req_i) <= 1 && !dev_reset_o) |=> !dev_reset_o)
		else $error("flushed illegal opcode caused reset");

	AST_LOCKOUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$countones(trap_req_i) > 1 |=> dev_reset_o && reset_cause_o.lockout)
		else $error("lockout did not reset");

	AST_TRAP_AT_BOUNDARY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(trap_grant_o.valid) |-> $past(insn_done_i))
		else $error("trap presented off an instruction boundary");

	AST_TRAP_LEVEL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		trap_grant_o.valid |-> trap_grant_o.level[3] && trap_grant_o.level == {1'b1, trap_grant_o.vector})
		else $error("trap level outside eight to fifteen");

	AST_BAD_VECTOR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(trap_vec_taken_i && trap_vec_addr_i < 24'h000100 && !soft_rst) |=> trap_pend_q[4])
		else $error("invalid vector did not raise address error");

	AST_BOOT_START: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(boot_st_q == BOOT_TARGET && boot_word_valid_i && !soft_rst)
			|=> start_valid_o && start_addr_o == $past(boot_word_i) ##1 !start_valid_o)
		else $error("start address not taken from target word");

	AST_PC_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(dev_reset_o) |-> boot_fetch_req_o && boot_fetch_addr_o == 24'h000000)
		else $error("start-up fetch not at zero");
endmodule // vrt_ctrl
`default_nettype wire

//--- design/vrt_pkg.sv
// Package: constants and carrier types for the vector, reset and trap logic
package vrt_pkg;
	// ==========================================================
	// Interrupt numbering
	localparam int NUM_SRC = 54;
	localparam int IDX_W = 6;
	localparam logic [7:0] IRQ_VECTOR_OFFSET = 8'h08;
	localparam logic [IDX_W-1:0] EXT_REQ0_NUM = 6'h00;
	localparam logic [IDX_W-1:0] SERIAL1_RX_NUM = 6'h09;
	localparam logic [IDX_W-1:0] SERIAL1_TX_NUM = 6'h0a;
	localparam logic [2:0] LEVEL_OFF = 3'h0;
	localparam logic [3:0] LEVEL_MAX_MASKABLE = 4'h7;

	// ==========================================================
	// Trap levels
	localparam int NUM_TRAP = 8;
	localparam logic [3:0] TRAP_LEVEL_BASE = 4'h8;
	localparam logic [2:0] ADDR_ERR_IDX = 3'h4;

	// ==========================================================
	// Program memory
	localparam int PC_W = 24;
	localparam logic [PC_W-1:0] BOOT_GOTO_ADDR = 24'h000000;
	localparam logic [PC_W-1:0] BOOT_TARGET_ADDR = 24'h000002;
	localparam logic [PC_W-1:0] VECTOR_SPACE_END = 24'h000100;
	localparam logic [PC_W-1:0] PROG_MEM_END_DEFAULT = 24'h008000;

	// ==========================================================
	// Device reset pulse
	localparam logic [3:0] DEV_RESET_CYCLES = 4'h4;

	typedef enum logic [1:0] {
		BOOT_GOTO,
		BOOT_TARGET,
		BOOT_RUN
	} vrt_boot_e;

	typedef struct packed {
		logic watchdog;
		logic uninit_wreg;
		logic illegal_op;
		logic supply_dip;
		logic lockout;
	} vrt_reset_cause_s;

	typedef struct packed {
		logic valid;
		logic [IDX_W-1:0] number;
		logic [7:0] vector;
		logic [2:0] level;
	} vrt_irq_grant_s;

	typedef struct packed {
		logic valid;
		logic [3:0] level;
		logic [2:0] vector;
	} vrt_trap_grant_s;
endpackage : vrt_pkg

//--- tb/vrt_core_model.sv
// Core-side partner model: serves boot fetches and acknowledges presented traps
`timescale 1ns/1ps
`default_nettype none
module vrt_core_model #(
	parameter logic [23:0] JUMP_WORD = 24'h040000,
	parameter logic [23:0] START_ADDR = 24'h000200
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic boot_fetch_req_i,
	input wire logic [vrt_pkg::PC_W-1:0] boot_fetch_addr_i,
	input wire vrt_pkg::vrt_trap_grant_s trap_grant_i,
	output logic boot_word_valid_o,
	output logic [vrt_pkg::PC_W-1:0] boot_word_o,
	output logic trap_ack_o
);
	import vrt_pkg::*;
	logic give;
	assign give = rst_n_i && boot_fetch_req_i && !boot_word_valid_o;
	// ==========================================================
	// Boot memory
	// A gap follows each word so the fetch address moves before the next one
	always_ff @(posedge clk_i) begin
		boot_word_valid_o <= give;
		if (give) begin
			boot_word_o <= (boot_fetch_addr_i == BOOT_GOTO_ADDR) ? JUMP_WORD : START_ADDR;
		end else begin
			boot_word_o <= ~boot_word_o;
		end
	end
	// ==========================================================
	// Trap acknowledge, one pulse per presented trap
	always_ff @(posedge clk_i) begin
		trap_ack_o <= rst_n_i && trap_grant_i.valid && !trap_ack_o;
	end
endmodule // vrt_core_model
`default_nettype wire

//--- tb/vrt_ctrl_bench.sv
// Self-checking bench for the vector, reset and trap logic
`timescale 1ns/1ps
`default_nettype none
module vrt_ctrl_bench;
	import vrt_pkg::*;
	localparam logic [23:0] START = 24'h000200;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [NUM_SRC-1:0] flag = '0;
	logic [NUM_SRC-1:0] en = '1;
	logic [3*NUM_SRC-1:0] lvl = '0;
	logic ext0 = 1'b0, rx = 1'b0, tx = 1'b0, done = 1'b0, ret = 1'b0, taken = 1'b0;
	logic wdog = 1'b0, uninit = 1'b0, ill = 1'b0, flush = 1'b0, dip = 1'b0;
	logic [3:0] cpu = 4'h0;
	logic [7:0] trq = 8'h00;
	logic [23:0] vaddr = 24'h000000;
	logic bw_v, ack;
	logic [23:0] bw;
	vrt_irq_grant_s ig;
	vrt_trap_grant_s tg;
	vrt_reset_cause_s cause;
	logic top, dev_rst, freq, sv;
	logic [23:0] faddr, saddr;
	int failures = 0;
	int samples_checked = 0;
	always #2.5 clk_i = ~clk_i;
	vrt_ctrl i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .irq_flag_i(flag), .irq_enable_i(en),
		.irq_level_i(lvl), .external_request_zero_i(ext0), .serial1_receive_request_i(rx),
		.serial1_transmit_request_i(tx), .cpu_priority_level_i(cpu), .trap_req_i(trq),
		.insn_done_i(done), .trap_ack_i(ack), .trap_return_i(ret), .trap_vec_taken_i(taken),
		.trap_vec_addr_i(vaddr), .watchdog_expired_i(wdog), .uninit_wreg_ptr_i(uninit),
		.illegal_opcode_exec_i(ill), .insn_flushed_i(flush), .supply_dip_reset_i(dip),
		.boot_word_valid_i(bw_v), .boot_word_i(bw), .irq_grant_o(ig), .trap_grant_o(tg),
		.priority_top_bit_o(top), .dev_reset_o(dev_rst), .reset_cause_o(cause),
		.boot_fetch_req_o(freq), .boot_fetch_addr_o(faddr), .start_valid_o(sv),
		.start_addr_o(saddr));
	vrt_core_model #(.START_ADDR(START)) i_core (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.boot_fetch_req_i(freq), .boot_fetch_addr_i(faddr), .trap_grant_i(tg),
		.boot_word_valid_o(bw_v), .boot_word_o(bw), .trap_ack_o(ack));
	// ==========================================================
	// Helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	function automatic logic [NUM_SRC-1:0] b(input int i);
		return {{(NUM_SRC-1){1'b0}}, 1'b1} << i;
	endfunction
	task automatic tally_and_finish;
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic boot_done;
		for (int i = 0; i < 60 && sv !== 1'b1; i++) begin
			tick(1);
		end
		chk("start_valid", 1, sv);
		chk("start_addr", START, saddr);
		chk("fetch_req_end", 0, freq);
	endtask
	task automatic arb(input logic [NUM_SRC-1:0] f, input logic [3:0] c, input logic ok,
		input logic [5:0] n, input logic [2:0] l);
		@(posedge clk_i);
		flag <= f;
		ext0 <= f[0];
		rx <= f[9];
		tx <= f[10];
		cpu <= c;
		tick(3);
		chk("irq_valid", ok, ig.valid);
		if (ok) begin
			chk("irq_number", n, ig.number);
			chk("irq_vector", n + IRQ_VECTOR_OFFSET, ig.vector);
			chk("irq_level", l, ig.level);
		end
	endtask
	task automatic trap_one(input logic [7:0] req, input logic [23:0] va, input logic [3:0] c,
		input logic ok, input logic [3:0] l);
		@(posedge clk_i);
		cpu <= c;
		trq <= req;
		taken <= (req == 8'h00);
		vaddr <= va;
		@(posedge clk_i);
		trq <= 8'h00;
		taken <= 1'b0;
		tick(3);
		chk("trap_early", 0, tg.valid);
		@(posedge clk_i);
		done <= 1'b1;
		@(posedge clk_i);
		done <= 1'b0;
		#1;
		chk("trap_valid", ok, tg.valid);
		if (ok) begin
			chk("trap_level", l, tg.level);
			chk("trap_vector", l - TRAP_LEVEL_BASE, tg.vector);
		end
		tick(4);
	endtask
	// Cause index k follows the cause struct, watchdog at bit 4 down to lockout at bit 0
	task automatic dev_case(input int k, input logic fl, input logic hit, input int hold);
		int cnt;
		cnt = 0;
		@(posedge clk_i);
		wdog <= (k == 4);
		uninit <= (k == 3);
		ill <= (k == 2);
		flush <= fl;
		dip <= (k == 1);
		trq <= (k == 0) ? 8'h05 : 8'h00;
		repeat (hold) @(posedge clk_i);
		{wdog, uninit, ill, flush, dip} <= 5'h00;
		trq <= 8'h00;
		#1;
		for (int i = 0; i < 12; i++) begin
			if (dev_rst === 1'b1) begin
				cnt++;
			end else if (cnt != 0) begin
				break;
			end
			tick(1);
		end
		if (hit && hold == 1) begin
			chk("reset_cycles", DEV_RESET_CYCLES, cnt);
		end else begin
			chk("reset_seen", hit, cnt != 0);
		end
		if (hit) begin
			chk("reset_cause", 32'h1 << k, cause);
			boot_done();
		end
	endtask
	// ==========================================================
	task automatic scen_arbitration;
		arb(b(9) | b(10), 4'h2, 1, 9, 3);
		@(posedge clk_i);
		en[9] <= 1'b0;
		arb(b(9) | b(10), 4'h2, 1, 10, 3);
		@(posedge clk_i);
		en[9] <= 1'b1;
		arb(b(0), 4'h0, 1, 0, 1);
		arb(b(5) | b(9), 4'h2, 1, 5, 6);
		arb(b(20), 4'h7, 0, 0, 0);
		arb(b(20), 4'h6, 1, 20, 7);
		@(posedge clk_i);
		lvl[15 +: 3] <= 3'h0;
		arb(b(5), 4'h0, 0, 0, 0);
		arb('0, 4'h0, 0, 0, 0);
	endtask
	// Four nested traps: the top bit must hold until the last return
	task automatic scen_traps;
		trap_one(8'h08, 24'h0, 4'h0, 1, 4'hb);
		chk("top_bit", 1, top);
		trap_one(8'h01, 24'h0, 4'h7, 1, 4'h8);
		trap_one(8'h00, 24'h000200, 4'h0, 0, 4'h0);
		trap_one(8'h00, 24'h000010, 4'h0, 1, 4'hc);
		trap_one(8'h00, PROG_MEM_END_DEFAULT, 4'h0, 1, 4'hc);
		repeat (3) begin
			@(posedge clk_i);
			ret <= 1'b1;
			@(posedge clk_i);
			ret <= 1'b0;
		end
		tick(2);
		chk("top_bit_nested", 1, top);
		@(posedge clk_i);
		ret <= 1'b1;
		@(posedge clk_i);
		ret <= 1'b0;
		tick(2);
		chk("top_bit_clear", 0, top);
	endtask
	task automatic scen_reset_sources;
		dev_case(2, 1, 0, 1);
		dev_case(2, 0, 1, 1);
		dev_case(4, 0, 1, 1);
		dev_case(3, 0, 1, 1);
		dev_case(1, 0, 1, 6);
		dev_case(0, 0, 1, 1);
	endtask
	// Main sequence
	initial begin
		repeat (11) @(posedge clk_i);
		#1;
		chk("fetch_addr", 0, faddr);
		chk("fetch_req", 1, freq);
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		lvl[0 +: 3] <= 3'h1;
		lvl[15 +: 3] <= 3'h6;
		lvl[27 +: 6] <= 6'h1b;
		lvl[60 +: 3] <= 3'h7;
		boot_done();
		scen_arbitration();
		scen_traps();
		scen_reset_sources();
		tally_and_finish();
	end
	// Whole run needs well under 1000 cycles, so 4000 marks a hang
	initial begin
		#20000;
		failures++;
		tally_and_finish();
	end
endmodule // vrt_ctrl_bench
`default_nettype wire
